// >>> shared/blit_pkg.sv
package blit_pkg;
  localparam int unsigned REG_AW = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIX_W  = 24;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_OP       = 8'h91;
  localparam logic [7:0] IDX_DEPTH    = 8'h92;
  localparam logic [7:0] IDX_ALPHA    = 8'hB5;
  localparam logic [7:0] IDX_FG_R     = 8'hD2;
  localparam logic [7:0] IDX_FG_G     = 8'hD3;
  localparam logic [7:0] IDX_FG_B     = 8'hD4;
  localparam logic [7:0] IDX_BG_R     = 8'hD5;
  localparam logic [7:0] IDX_BG_G     = 8'hD6;
  localparam logic [7:0] IDX_BG_B     = 8'hD7;
  localparam logic [7:0] IDX_CTRL     = 8'hE0;
  localparam logic [7:0] IDX_WIN_W    = 8'hE1;
  localparam logic [7:0] IDX_WIN_H    = 8'hE2;
  localparam logic [7:0] IDX_HOST_DAT = 8'hE3;

  localparam logic [3:0] OP_HOST_ROP     = 4'h0;
  localparam logic [3:0] OP_COPY_ROP     = 4'h2;
  localparam logic [3:0] OP_HOST_KEY     = 4'h4;
  localparam logic [3:0] OP_COPY_KEY     = 4'h5;
  localparam logic [3:0] OP_PAT_ROP      = 4'h6;
  localparam logic [3:0] OP_PAT_KEY      = 4'h7;
  localparam logic [3:0] OP_HOST_EXP     = 4'h8;
  localparam logic [3:0] OP_HOST_EXP_KEY = 4'h9;
  localparam logic [3:0] OP_COPY_OPA     = 4'hA;
  localparam logic [3:0] OP_HOST_OPA     = 4'hB;
  localparam logic [3:0] OP_SOLID        = 4'hC;
  localparam logic [3:0] OP_COPY_EXP     = 4'hE;
  localparam logic [3:0] OP_COPY_EXP_KEY = 4'hF;

  localparam int unsigned OP_HI_LSB        = 4;
  localparam int unsigned DEPTH_LSB        = 5;
  localparam int unsigned CTRL_START       = 0;
  localparam int unsigned CTRL_PIXEL_ALPHA = 1;
  localparam int unsigned CTRL_PAT16       = 2;
  localparam int unsigned STAT_BUSY        = 3;

  localparam logic [1:0]  DEPTH_8   = 2'b00;
  localparam logic [1:0]  DEPTH_16  = 2'b01;
  localparam logic [5:0]  ALPHA_ONE = 6'd32;
  localparam logic [5:0]  AL8_1     = 6'd10;
  localparam logic [5:0]  AL8_2     = 6'd21;
  localparam logic [15:0] PAT_SMALL = 16'd8;
  localparam logic [15:0] PAT_LARGE = 16'd16;
  localparam logic [4:0]  WORD_8    = 5'd8;
  localparam logic [4:0]  WORD_16   = 5'd16;
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [15:0] WIN_RST   = 16'h0001;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SRC  = 3'b001,
    S_RD1  = 3'b011,
    S_CALC = 3'b010,
    S_WR   = 3'b110,
    S_NEXT = 3'b111
  } blit_state_t;
endpackage

// >>> verilog/blit_operation_engine.sv
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module blit_operation_engine #(
  parameter int unsigned AW       = 20,
  parameter int unsigned BUS_BITS = 16
) (
  input  wire logic                          ref_clk,
  input  wire logic                          arst_n,
  input  wire logic [blit_pkg::REG_AW-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [blit_pkg::DATA_W-1:0]   avs_writedata,
  output logic      [blit_pkg::DATA_W-1:0]   avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic [AW-1:0]                 s0_base,
  input  wire logic [AW-1:0]                 s1_base,
  input  wire logic [AW-1:0]                 dt_base,
  input  wire logic [AW-1:0]                 line_stride,
  output logic                               mem_read,
  output logic                               mem_write,
  output logic      [AW-1:0]                 mem_address,
  output logic      [blit_pkg::PIX_W-1:0]    mem_writedata,
  input  wire logic [blit_pkg::PIX_W-1:0]    mem_readdata,
  input  wire logic                          mem_waitrequest,
  output logic                               busy
);
  import blit_pkg::*;

  // refuse widths that the word counter and address arithmetic cannot serve
  if (BUS_BITS != 8 && BUS_BITS != 16) $error("BUS_BITS must be 8 or 16");
  if (AW < 8) $error("AW too small");

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] rop_fn(input logic [3:0] f, input logic [23:0] a,
                                         input logic [23:0] b);
    logic [23:0] r;
    r = '0;
    for (int i = 0; i < 24; i++) r[i] = f[{a[i], b[i]}];
    return r;
  endfunction

  function automatic logic [23:0] pack_fn(input logic [1:0] d, input logic [7:0] r,
                                          input logic [7:0] g, input logic [7:0] b);
    case (d)
      DEPTH_8:  return {16'h0000, r[7:5], g[7:5], b[7:6]};
      DEPTH_16: return {8'h00, r[7:3], g[7:2], b[7:3]};
      default:  return {r, g, b};
    endcase
  endfunction

  function automatic logic [23:0] mask_fn(input logic [1:0] d);
    case (d)
      DEPTH_8:  return 24'h0000FF;
      DEPTH_16: return 24'h00FFFF;
      default:  return 24'hFFFFFF;
    endcase
  endfunction

  function automatic logic [23:0] unpack_fn(input logic [1:0] d, input logic [23:0] p);
    case (d)
      DEPTH_8:  return {p[7:5], 5'h00, p[4:2], 5'h00, p[1:0], 6'h00};
      DEPTH_16: return {p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
      default:  return p;
    endcase
  endfunction

  function automatic logic [7:0] mix_fn(input logic [7:0] a, input logic [7:0] b,
                                        input logic [5:0] al);
    logic [13:0] t;
    t = 14'(a) * 14'(al) + 14'(b) * 14'(ALPHA_ONE - al);
    return t[12:5];
  endfunction

  function automatic logic [AW-1:0] addr_fn(input logic [AW-1:0] base,
                                            input logic [15:0] y, input logic [15:0] x);
    return AW'(base + AW'(AW'(y) * line_stride) + AW'(x));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file and bus slave
  logic [7:0]  op_reg, depth_reg, alpha_reg, ctrl_reg;
  logic [7:0]  fg_r_reg, fg_g_reg, fg_b_reg, bg_r_reg, bg_g_reg, bg_b_reg;
  logic [15:0] win_w_reg, win_h_reg;
  logic [7:0]  op_next, depth_next, alpha_next, ctrl_next;
  logic [7:0]  fg_r_next, fg_g_next, fg_b_next, bg_r_next, bg_g_next, bg_b_next;
  logic [15:0] win_w_next, win_h_next;
  logic        rd_done_reg, rd_done_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  idx;
  logic        wr_ok, host_wait, host_take, start_go, op_ok;
  blit_state_t state_reg, state_next;

  assign idx  = avs_address[REG_AW-1:2];
  assign busy = (state_reg != S_IDLE);

  always_comb begin
    case (op_reg[3:0])
      OP_HOST_ROP, OP_COPY_ROP, OP_HOST_KEY, OP_COPY_KEY, OP_PAT_ROP, OP_PAT_KEY,
      OP_HOST_EXP, OP_HOST_EXP_KEY, OP_COPY_OPA, OP_HOST_OPA, OP_SOLID,
      OP_COPY_EXP, OP_COPY_EXP_KEY: op_ok = 1'b1;
      default: op_ok = 1'b0;
    endcase
  end

  // host data stalls the bus while the engine is busy but not yet asking
  assign host_take = avs_write && (idx == IDX_HOST_DAT) && host_wait;
  assign avs_waitrequest = (avs_read && !rd_done_reg) ||
                           (avs_write && (idx == IDX_HOST_DAT) && busy && !host_wait);
  assign wr_ok = avs_write && !avs_waitrequest;
  assign start_go = wr_ok && (idx == IDX_CTRL) && avs_writedata[CTRL_START] &&
                    !busy && op_ok;
  assign avs_readdata = rdata_reg;

  always_comb begin
    op_next = op_reg;  depth_next = depth_reg;  alpha_next = alpha_reg;
    ctrl_next = ctrl_reg;
    fg_r_next = fg_r_reg;  fg_g_next = fg_g_reg;  fg_b_next = fg_b_reg;
    bg_r_next = bg_r_reg;  bg_g_next = bg_g_reg;  bg_b_next = bg_b_reg;
    win_w_next = win_w_reg;  win_h_next = win_h_reg;
    rd_done_next = avs_read && !rd_done_reg;
    rdata_next = rdata_reg;
    if (wr_ok) begin
      case (idx)
        IDX_OP:    op_next = avs_writedata[7:0];
        IDX_DEPTH: depth_next = avs_writedata[7:0];
        IDX_ALPHA: alpha_next = avs_writedata[7:0];
        IDX_FG_R:  fg_r_next = avs_writedata[7:0];
        IDX_FG_G:  fg_g_next = avs_writedata[7:0];
        IDX_FG_B:  fg_b_next = avs_writedata[7:0];
        IDX_BG_R:  bg_r_next = avs_writedata[7:0];
        IDX_BG_G:  bg_g_next = avs_writedata[7:0];
        IDX_BG_B:  bg_b_next = avs_writedata[7:0];
        IDX_CTRL:  ctrl_next = {5'h00, avs_writedata[CTRL_PAT16:CTRL_PIXEL_ALPHA], 1'b0};
        IDX_WIN_W: win_w_next = avs_writedata[15:0];
        IDX_WIN_H: win_h_next = avs_writedata[15:0];
        default: ;
      endcase
    end
    if (avs_read && !rd_done_reg) begin
      case (idx)
        IDX_OP:    rdata_next = {24'h000000, op_reg};
        IDX_DEPTH: rdata_next = {24'h000000, depth_reg};
        IDX_ALPHA: rdata_next = {24'h000000, alpha_reg};
        IDX_FG_R:  rdata_next = {24'h000000, fg_r_reg};
        IDX_FG_G:  rdata_next = {24'h000000, fg_g_reg};
        IDX_FG_B:  rdata_next = {24'h000000, fg_b_reg};
        IDX_BG_R:  rdata_next = {24'h000000, bg_r_reg};
        IDX_BG_G:  rdata_next = {24'h000000, bg_g_reg};
        IDX_BG_B:  rdata_next = {24'h000000, bg_b_reg};
        IDX_CTRL:  rdata_next = {24'h000000, ctrl_reg | (8'(busy) << STAT_BUSY)};
        IDX_WIN_W: rdata_next = {16'h0000, win_w_reg};
        IDX_WIN_H: rdata_next = {16'h0000, win_h_reg};
        default:   rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_reg <= REG_RST;  depth_reg <= REG_RST;  alpha_reg <= REG_RST;
      ctrl_reg <= REG_RST;
      fg_r_reg <= REG_RST;  fg_g_reg <= REG_RST;  fg_b_reg <= REG_RST;
      bg_r_reg <= REG_RST;  bg_g_reg <= REG_RST;  bg_b_reg <= REG_RST;
      win_w_reg <= WIN_RST;  win_h_reg <= WIN_RST;
      rd_done_reg <= 1'b0;  rdata_reg <= 32'h00000000;
    end else begin
      op_reg <= op_next;  depth_reg <= depth_next;  alpha_reg <= alpha_next;
      ctrl_reg <= ctrl_next;
      fg_r_reg <= fg_r_next;  fg_g_reg <= fg_g_next;  fg_b_reg <= fg_b_next;
      bg_r_reg <= bg_r_next;  bg_g_reg <= bg_g_next;  bg_b_reg <= bg_b_next;
      win_w_reg <= win_w_next;  win_h_reg <= win_h_next;
      rd_done_reg <= rd_done_next;  rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine
  logic [3:0]  run_op_reg, run_op_next, fn, idx_reg, idx_next, lim;
  logic [15:0] x_reg, x_next, y_reg, y_next, wcnt_reg, wcnt_next, word_reg, word_next;
  logic [23:0] s0_reg, s0_next, s1_reg, s1_next, res_reg, res_next;
  logic        have_reg, have_next, first_reg, first_next, skip_reg, skip_next;
  logic        is_exp, exp_host, exp_key, host_src, mem_s0, need_s1, is_key, is_pat;
  logic        is_opa, cur_bit, key_hit, row_end, last_pix;
  logic [1:0]  dep;
  logic [23:0] msk, keyp, fgp, bgp, s1c, u0, blend;
  logic [5:0]  al;
  logic [4:0]  wbits;
  logic [15:0] psz, poff;

  assign fn = op_reg[OP_HI_LSB +: 4];
  assign dep = depth_reg[DEPTH_LSB +: 2];
  assign msk = mask_fn(dep);
  assign keyp = pack_fn(dep, bg_r_reg, bg_g_reg, bg_b_reg);
  assign fgp = pack_fn(dep, fg_r_reg, fg_g_reg, fg_b_reg);
  assign bgp = keyp;
  assign is_exp = (run_op_reg == OP_HOST_EXP) || (run_op_reg == OP_HOST_EXP_KEY) ||
                  (run_op_reg == OP_COPY_EXP) || (run_op_reg == OP_COPY_EXP_KEY);
  assign exp_host = (run_op_reg == OP_HOST_EXP) || (run_op_reg == OP_HOST_EXP_KEY);
  assign exp_key = (run_op_reg == OP_HOST_EXP_KEY) || (run_op_reg == OP_COPY_EXP_KEY);
  assign host_src = (run_op_reg == OP_HOST_ROP) || (run_op_reg == OP_HOST_KEY) ||
                    (run_op_reg == OP_HOST_OPA);
  assign is_pat = (run_op_reg == OP_PAT_ROP) || (run_op_reg == OP_PAT_KEY);
  assign is_key = (run_op_reg == OP_HOST_KEY) || (run_op_reg == OP_COPY_KEY) ||
                  (run_op_reg == OP_PAT_KEY);
  assign is_opa = (run_op_reg == OP_COPY_OPA) || (run_op_reg == OP_HOST_OPA);
  assign mem_s0 = (run_op_reg == OP_COPY_ROP) || (run_op_reg == OP_COPY_KEY) || is_pat ||
                  (run_op_reg == OP_COPY_OPA);
  assign need_s1 = (run_op_reg == OP_HOST_ROP) || (run_op_reg == OP_COPY_ROP) ||
                   (run_op_reg == OP_PAT_ROP) || is_opa;
  // source word width: bus width for host expansion, depth field otherwise
  assign wbits = exp_host ? 5'(BUS_BITS) : ((dep == DEPTH_8) ? WORD_8 : WORD_16);
  assign lim = first_reg ? op_reg[OP_HI_LSB +: 4] : 4'(BUS_BITS - 1);
  assign cur_bit = word_reg[idx_reg];
  assign key_hit = ((s0_reg & msk) == keyp);
  assign psz = ctrl_reg[CTRL_PAT16] ? PAT_LARGE : PAT_SMALL;
  assign poff = 16'(((y_reg & (psz - 16'd1)) * psz) + (x_reg & (psz - 16'd1)));
  assign row_end = (x_reg == win_w_reg - 16'd1);
  assign last_pix = row_end && (y_reg == win_h_reg - 16'd1);
  assign host_wait = (state_reg == S_SRC) && ((host_src && !is_exp) || (exp_host && !have_reg));

  // alpha and second colour for the blend
  always_comb begin
    al = (alpha_reg[5:0] > ALPHA_ONE) ? ALPHA_ONE : alpha_reg[5:0];
    s1c = unpack_fn(dep, s1_reg);
    if (ctrl_reg[CTRL_PIXEL_ALPHA]) begin
      if (dep == DEPTH_16) begin
        al = (s1_reg[15:12] == 4'hF) ? ALPHA_ONE : {1'b0, s1_reg[15:12], 1'b0};
        s1c = {s1_reg[11:8], 4'h0, s1_reg[7:4], 4'h0, s1_reg[3:0], 4'h0};
      end else if (dep == DEPTH_8) begin
        case (s1_reg[7:6])
          2'b00:   al = 6'd0;
          2'b01:   al = AL8_1;
          2'b10:   al = AL8_2;
          default: al = ALPHA_ONE;
        endcase
        s1c = {s1_reg[5:4], 6'h00, s1_reg[3:2], 6'h00, s1_reg[1:0], 6'h00};
      end
    end
    u0 = unpack_fn(dep, s0_reg);
    blend = pack_fn(dep, mix_fn(u0[23:16], s1c[23:16], al), mix_fn(u0[15:8], s1c[15:8], al),
                    mix_fn(u0[7:0], s1c[7:0], al));
  end

  always_comb begin
    state_next = state_reg;  run_op_next = run_op_reg;
    x_next = x_reg;  y_next = y_reg;  wcnt_next = wcnt_reg;  word_next = word_reg;
    idx_next = idx_reg;  have_next = have_reg;  first_next = first_reg;
    s0_next = s0_reg;  s1_next = s1_reg;  res_next = res_reg;  skip_next = skip_reg;
    case (state_reg)
      S_IDLE: begin
        if (start_go) begin
          run_op_next = op_reg[3:0];
          x_next = 16'h0000;  y_next = 16'h0000;  wcnt_next = 16'h0000;
          have_next = 1'b0;  first_next = 1'b1;
          idx_next = (op_reg[3:1] == OP_HOST_EXP[3:1]) ? 4'h0 : fn;
          state_next = S_SRC;
        end
      end
      S_SRC: begin
        if (is_exp) begin
          if (have_reg) begin
            state_next = S_CALC;
          end else if (exp_host && host_take) begin
            word_next = 16'(avs_writedata[BUS_BITS-1:0]);
            have_next = 1'b1;
            state_next = S_CALC;
          end else if (!exp_host && !mem_waitrequest) begin
            word_next = mem_readdata[15:0];
            have_next = 1'b1;
            wcnt_next = wcnt_reg + 16'd1;
            state_next = S_CALC;
          end
        end else if (host_src) begin
          if (host_take) begin
            s0_next = avs_writedata[23:0] & msk;
            state_next = need_s1 ? S_RD1 : S_CALC;
          end
        end else if (mem_s0) begin
          if (!mem_waitrequest) begin
            s0_next = mem_readdata & msk;
            state_next = need_s1 ? S_RD1 : S_CALC;
          end
        end else begin
          state_next = S_CALC;
        end
      end
      S_RD1: begin
        if (!mem_waitrequest) begin
          s1_next = mem_readdata & msk;
          state_next = S_CALC;
        end
      end
      S_CALC: begin
        skip_next = 1'b0;
        if (is_exp) begin
          res_next = cur_bit ? fgp : bgp;
          skip_next = exp_key && !cur_bit;
        end else if (is_key) begin
          res_next = s0_reg;
          skip_next = key_hit;
        end else if (is_opa) begin
          res_next = blend;
        end else if (run_op_reg == OP_SOLID) begin
          res_next = fgp;
        end else begin
          res_next = rop_fn(fn, s0_reg, s1_reg) & msk;
        end
        state_next = skip_next ? S_NEXT : S_WR;
      end
      S_WR: begin
        if (!mem_waitrequest) state_next = S_NEXT;
      end
      S_NEXT: begin
        state_next = S_SRC;
        if (exp_host) begin
          if (idx_reg == lim) begin
            have_next = 1'b0;  first_next = 1'b0;  idx_next = 4'h0;
          end else begin
            idx_next = idx_reg + 4'h1;
          end
        end else if (is_exp) begin
          if (idx_reg == 4'h0) begin
            have_next = 1'b0;  first_next = 1'b0;  idx_next = 4'(wbits - 5'd1);
          end else begin
            idx_next = idx_reg - 4'h1;
          end
        end
        if (row_end) begin
          x_next = 16'h0000;
          y_next = y_reg + 16'd1;
          have_next = 1'b0;  first_next = 1'b1;  wcnt_next = 16'h0000;
          idx_next = exp_host ? 4'h0 : fn;
          if (last_pix) state_next = S_IDLE;
        end else begin
          x_next = x_reg + 16'd1;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;  run_op_reg <= 4'h0;
      x_reg <= 16'h0000;  y_reg <= 16'h0000;  wcnt_reg <= 16'h0000;  word_reg <= 16'h0000;
      idx_reg <= 4'h0;  have_reg <= 1'b0;  first_reg <= 1'b1;
      s0_reg <= 24'h000000;  s1_reg <= 24'h000000;  res_reg <= 24'h000000;
      skip_reg <= 1'b0;
    end else begin
      state_reg <= state_next;  run_op_reg <= run_op_next;
      x_reg <= x_next;  y_reg <= y_next;  wcnt_reg <= wcnt_next;  word_reg <= word_next;
      idx_reg <= idx_next;  have_reg <= have_next;  first_reg <= first_next;
      s0_reg <= s0_next;  s1_reg <= s1_next;  res_reg <= res_next;
      skip_reg <= skip_next;
    end
  end

  assign mem_read = ((state_reg == S_SRC) && (mem_s0 || (is_exp && !exp_host && !have_reg))) ||
                    (state_reg == S_RD1);
  assign mem_write = (state_reg == S_WR);
  assign mem_writedata = res_reg;

  always_comb begin
    case (state_reg)
      S_SRC:   mem_address = is_exp ? addr_fn(s0_base, y_reg, wcnt_reg) :
                             is_pat ? AW'(s0_base + AW'(poff)) :
                             addr_fn(s0_base, y_reg, x_reg);
      S_RD1:   mem_address = addr_fn(s1_base, y_reg, x_reg);
      S_WR:    mem_address = addr_fn(dt_base, y_reg, x_reg);
      default: mem_address = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  busy_status_a: assert property (avs_read && idx == IDX_CTRL && !avs_waitrequest |->
    avs_readdata[STAT_BUSY] == $past(busy)) else $error("busy bit wrong");
  start_run_a: assert property (start_go |=> busy && state_reg == S_SRC)
    else $error("start not taken");
  reserved_op_a: assert property (avs_write && idx == IDX_CTRL && !busy &&
    avs_writedata[CTRL_START] && !op_ok |=> !busy) else $error("reserved op started");
  solid_fill_a: assert property (mem_write && run_op_reg == OP_SOLID |->
    mem_writedata == fgp) else $error("solid fill colour wrong");
  rop_result_a: assert property (state_reg == S_CALC && !is_exp && !is_key && !is_opa &&
    run_op_reg != OP_SOLID |=> res_reg == (rop_fn($past(fn), $past(s0_reg), $past(s1_reg))
    & $past(msk))) else $error("raster result wrong");
  key_skip_a: assert property (state_reg == S_CALC && is_key && key_hit |=>
    state_reg == S_NEXT ##1 !mem_write) else $error("keyed pixel written");
  expand_fg_a: assert property (state_reg == S_CALC && is_exp && cur_bit |=>
    res_reg == $past(fgp) && state_reg == S_WR) else $error("set bit not fg");
  expand_tr_a: assert property (state_reg == S_CALC && exp_key && !cur_bit |=>
    skip_reg && state_reg == S_NEXT) else $error("clear bit written");
  forward_walk_a: assert property (state_reg == S_NEXT && !row_end |=>
    x_reg == $past(x_reg) + 16'd1 && y_reg == $past(y_reg)) else $error("walk not forward");
  window_end_a: assert property (state_reg == S_NEXT && last_pix |=> !busy)
    else $error("window end missed");

  solid_done_c: cover property (run_op_reg == OP_SOLID && state_reg == S_NEXT && last_pix);
  key_skip_c: cover property (state_reg == S_CALC && is_key && key_hit);
  host_word_c: cover property (host_take && exp_host);
  blend_c: cover property (mem_write && is_opa);
endmodule
`default_nettype wire

// >>> test/pixel_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  input  wire logic [19:0] mem_address,
  input  wire logic [23:0] mem_writedata,
  output logic      [23:0] mem_readdata,
  output logic             mem_waitrequest
);
  logic [23:0] mem [0:255];
  logic [23:0] last_reg = 24'h000000;
  logic        slow_reg = 1'b0;
  // stall every other cycle so the engine must hold its request
  assign mem_waitrequest = (mem_read | mem_write) & slow_reg;
  // no stale data outside a read
  assign mem_readdata = mem_read ? mem[mem_address[7:0]] : ~last_reg;
  always @(posedge ref_clk) begin
    slow_reg <= ~slow_reg;
    if (mem_read && !mem_waitrequest) last_reg <= mem[mem_address[7:0]];
    if (mem_write && !mem_waitrequest) mem[mem_address[7:0]] <= mem_writedata;
  end
endmodule
`default_nettype wire

// >>> test/blit_operation_engine_test.sv
`timescale 1ns/1ps
`default_nettype none
module blit_operation_engine_test;
  import blit_pkg::*;
  logic        ref_clk;
  logic        arst_n;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        mem_read;
  logic        mem_write;
  logic [19:0] mem_address;
  logic [23:0] mem_writedata;
  logic [23:0] mem_readdata;
  logic        mem_waitrequest;
  logic        busy;
  int          bad_count = 0;
  int          checks = 0;
  logic [31:0] q;
  logic [31:0] want;
  typedef struct {logic [7:0] op; logic [23:0] pix; logic [23:0] exp;} row_t;
  row_t rows [10] = '{'{8'hC0, 24'h123456, 24'h123456}, '{8'hE0, 24'h0F0F0F, 24'h3FFF0F},
    '{8'hA0, 24'h0F0F0F, 24'h30F000}, '{8'h04, 24'h112233, 24'hAAAAAA},
    '{8'h04, 24'h445566, 24'h445566}, '{8'h0C, 24'h000000, 24'h5A6B7C},
    '{8'hE2, 24'h0F0F0F, 24'h3FFF0F}, '{8'h0A, 24'h0F0F0F, 24'h1F7F07},
    '{8'h05, 24'h112233, 24'hAAAAAA}, '{8'hC6, 24'h445566, 24'h445566}};
  blit_operation_engine DUT (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .s0_base(20'h00010),
    .s1_base(20'h00030), .dt_base(20'h00020), .line_stride(20'h00004),
    .mem_read(mem_read), .mem_write(mem_write), .mem_address(mem_address),
    .mem_writedata(mem_writedata), .mem_readdata(mem_readdata),
    .mem_waitrequest(mem_waitrequest), .busy(busy));
  pixel_mem_model MEM (.ref_clk(ref_clk), .mem_read(mem_read), .mem_write(mem_write),
    .mem_address(mem_address), .mem_writedata(mem_writedata),
    .mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 400);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 400) begin
      bad_count++;
      report_and_stop();
    end
    @(posedge ref_clk);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_CTRL, 32'h0);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // start only from idle, then poll the status word until idle again
  task automatic run_op(input logic [7:0] op, input logic [23:0] pix, input logic host);
    bus(1'b1, IDX_OP, {24'h0, op});
    bus(1'b1, IDX_CTRL, 32'h1);
    if (host) bus(1'b1, IDX_HOST_DAT, {8'h0, pix});
    wait_idle();
  endtask
  // host expansion: window 18 wide, first word ends at bit 3, so two words per row
  task automatic expand(input logic [7:0] op, input logic [15:0] w0, input logic [15:0] w1);
    bus(1'b1, IDX_OP, {24'h0, op});
    bus(1'b1, IDX_CTRL, 32'h1);
    check("busy pin", 32'h1, {31'h0, busy});
    bus(1'b1, IDX_HOST_DAT, {16'h0, w0});
    bus(1'b1, IDX_HOST_DAT, {16'h0, w1});
    wait_idle();
  endtask
  initial begin
    arst_n = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, IDX_FG_R, 32'h0);
    check("fg_red_level reset", 32'h0, q);
    bus(1'b1, 8'hF0, 32'hFF);
    bus(1'b0, 8'hF0, 32'h0);
    check("unmapped read", 32'h0, q);
    bus(1'b1, IDX_DEPTH, 32'h40);
    foreach (rows[i]) begin
      bus(1'b1, IDX_FG_R + 8'(i % 3), 32'h5A + 32'(i % 3) * 32'h11);
      bus(1'b1, IDX_BG_R + 8'(i % 3), 32'h11 + 32'(i % 3) * 32'h11);
    end
    bus(1'b0, IDX_BG_B, 32'h0);
    check("bg_blue_level", 32'h33, q);
    bus(1'b1, IDX_ALPHA, 32'h10);
    foreach (rows[i]) begin
      MEM.mem[8'h10] = rows[i].pix;
      MEM.mem[8'h20] = 24'hAAAAAA;
      MEM.mem[8'h30] = 24'h30F000;
      run_op(rows[i].op, rows[i].pix,
             rows[i].op[3:0] inside {OP_HOST_ROP, OP_HOST_KEY, OP_HOST_OPA});
      check("dest pixel", {8'h0, rows[i].exp}, {8'h0, MEM.mem[8'h20]});
    end
    bus(1'b1, IDX_WIN_W, 32'h2);
    bus(1'b1, IDX_WIN_H, 32'h2);
    run_op(8'h0C, 24'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      want = {8'h0, MEM.mem[8'h20 + 4*(i/2) + i%2]};
      check("fill", 32'h5A6B7C, want);
    end
    bus(1'b1, IDX_WIN_W, 32'h12);
    bus(1'b1, IDX_WIN_H, 32'h1);
    MEM.mem[8'h32] = 24'hAAAAAA;
    expand(8'h38, 16'h0005, 16'hC001);
    for (int x = 0; x < 18; x++) begin
      want = (x == 0 || x == 2 || x == 4) ? 32'h5A6B7C : 32'h112233;
      check("expand pixel", want, {8'h0, MEM.mem[8'h20 + x]});
    end
    check("expand discard", 32'hAAAAAA, {8'h0, MEM.mem[8'h32]});
    MEM.mem[8'h21] = 24'hAAAAAA;
    expand(8'h39, 16'h0000, 16'h0000);
    check("expand keep", 32'hAAAAAA, {8'h0, MEM.mem[8'h21]});
    bus(1'b1, IDX_OP, 32'h01);
    bus(1'b1, IDX_CTRL, 32'h1);
    bus(1'b0, IDX_CTRL, 32'h0);
    check("reserved start busy", 32'h0, {31'h0, q[STAT_BUSY]});
    report_and_stop();
  end
endmodule
`default_nettype wire
